// ==== fsp_consts.svh ====
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ==========================================
// status byte layout
`define FSP_BIT_BUSY 0
`define FSP_BIT_WEL 1
`define FSP_BIT_BP_LO 2
`define FSP_BIT_BP_HI 4
`define FSP_BIT_LOCK 7
`define FSP_STATUS_RESET 8'h00

// ==========================================
// command codes
`define FSP_CMD_EN_WR 8'h06
`define FSP_CMD_DIS_WR 8'h04
`define FSP_CMD_ST_RD 8'h05
`define FSP_CMD_ST_WR 8'h01
`define FSP_CMD_PROG 8'h02
`define FSP_CMD_SECT_A 8'h20
`define FSP_CMD_SECT_B 8'hD7
`define FSP_CMD_BLOCK 8'hD8
`define FSP_CMD_CHIP_A 8'hC7
`define FSP_CMD_CHIP_B 8'h60

// ==========================================
// frame lengths in serial clocks
`define FSP_LEN_CMD 6'h08
`define FSP_LEN_ST_WR 6'h10
`define FSP_LEN_ADDR 6'h20
`define FSP_LEN_PROG 6'h28

// ==========================================
// timing
`define FSP_CLK_NS 10
`define FSP_OP_TIME_NS 20000
`define FSP_OP_CYCLES (`FSP_OP_TIME_NS / `FSP_CLK_NS)

`endif

// ==== fsp_pkg.sv ====
package fsp_pkg;

    typedef enum logic [2:0] {
        FSP_OP_NONE,
        FSP_OP_STATUS,
        FSP_OP_PROG,
        FSP_OP_SECTOR,
        FSP_OP_BLOCK,
        FSP_OP_CHIP
    } fsp_op_type;

endpackage : fsp_pkg

// ==== fsp_status_protect.sv ====
`include "fsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fsp_status_protect
    import fsp_pkg::*;
#(
    parameter bit IS_4MBIT = 1'b1,
    parameter int OP_CYCLES = `FSP_OP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic o_busy,
    output logic o_wel,
    output logic [7:0] o_status,
    output logic o_op_start,
    output fsp_op_type o_op_kind,
    output logic [23:0] o_op_addr
);

    // ==========================================
    // address map helpers
    function automatic logic [3:0] fsp_block_of(input logic [23:0] addr);
        fsp_block_of = IS_4MBIT ? {1'b0, addr[18:16]} : {2'b00, addr[17:16]};
    endfunction : fsp_block_of

    function automatic logic fsp_protected(input logic [23:0] addr, input logic [2:0] bp);
        logic [3:0] base;
        base = 4'h0;
        if (IS_4MBIT) begin
            unique case (bp)
                3'h0: base = 4'h8;
                3'h1: base = 4'h7;
                3'h2: base = 4'h6;
                3'h3: base = 4'h4;
                default: base = 4'h0;
            endcase
        end else begin
            unique case (bp[1:0])
                2'h0: base = 4'h4;
                2'h1: base = 4'h3;
                2'h2: base = 4'h2;
                2'h3: base = 4'h0;
            endcase
        end
        fsp_protected = fsp_block_of(addr) >= base;
    endfunction : fsp_protected

    // ==========================================
    // link side, runs on the serial clock
    logic first_q;
    logic [5:0] lk_cnt_q;
    logic [2:0] lk_mod_q;
    logic [7:0] lk_op_q;
    logic [7:0] lk_wdat_q;
    logic [23:0] lk_addr_q;
    logic [7:0] lk_st_m_q;
    logic [7:0] lk_st_q;

    // marks the next edge as the first of a frame
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // words hold still after the frame until the next one starts
    always_ff @(posedge i_sck) begin
        if (first_q) begin
            lk_cnt_q <= 6'h01;
            lk_mod_q <= 3'h1;
        end else begin
            lk_mod_q <= lk_mod_q + 3'h1;
            if (lk_cnt_q != 6'h3F) begin
                lk_cnt_q <= lk_cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge i_sck) begin
        if (first_q || lk_cnt_q < `FSP_LEN_CMD) begin
            lk_op_q <= {lk_op_q[6:0], i_si};
        end
    end

    always_ff @(posedge i_sck) begin
        if (!first_q && lk_cnt_q >= `FSP_LEN_CMD && lk_cnt_q < `FSP_LEN_ADDR) begin
            lk_addr_q <= {lk_addr_q[22:0], i_si};
        end
    end

    always_ff @(posedge i_sck) begin
        if (!first_q && lk_cnt_q >= `FSP_LEN_CMD && lk_cnt_q < `FSP_LEN_ST_WR) begin
            lk_wdat_q <= {lk_wdat_q[6:0], i_si};
        end
    end

    // status bits are synced bit by bit, though busy, wel, lock and bp can change in the same cycle
    always_ff @(posedge i_sck) begin
        lk_st_m_q <= o_status;
        lk_st_q <= lk_st_m_q;
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else if (lk_cnt_q >= `FSP_LEN_CMD && lk_op_q == `FSP_CMD_ST_RD) begin
            o_so_oe <= 1'b1;
            o_so <= lk_st_q[3'h7 - lk_mod_q];
        end else begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end
    end

    // ==========================================
    // system side synchronisers
    logic cs_m_q;
    logic cs_s_q;
    logic cs_d_q;
    logic wp_m_q;
    logic wp_s_q;
    logic frame_end;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
        end else begin
            cs_m_q <= i_cs_n;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_m_q <= 1'b0;
            wp_s_q <= 1'b0;
        end else begin
            wp_m_q <= i_wp_n;
            wp_s_q <= wp_m_q;
        end
    end

    assign frame_end = cs_s_q & ~cs_d_q;

    // ==========================================
    // command decode at frame end
    logic lock_q;
    logic [2:0] bp_q;
    logic busy_q;
    logic wel_q;
    logic locked;
    logic whole;
    logic wen_set;
    logic wen_clr;
    fsp_op_type kind_d;
    logic [23:0] addr_d;

    assign locked = lock_q & ~wp_s_q;
    assign whole = lk_mod_q == 3'h0;

    always_comb begin
        wen_set = 1'b0;
        wen_clr = 1'b0;
        kind_d = FSP_OP_NONE;
        addr_d = lk_addr_q;
        if (frame_end && !busy_q && whole && lk_cnt_q >= `FSP_LEN_CMD) begin
            unique case (lk_op_q)
                `FSP_CMD_EN_WR: wen_set = lk_cnt_q == `FSP_LEN_CMD;
                `FSP_CMD_DIS_WR: wen_clr = lk_cnt_q == `FSP_LEN_CMD;
                `FSP_CMD_ST_WR: begin
                    if (wel_q && !locked && lk_cnt_q >= `FSP_LEN_ST_WR) begin
                        kind_d = FSP_OP_STATUS;
                    end
                end
                `FSP_CMD_PROG: begin
                    if (wel_q && lk_cnt_q >= `FSP_LEN_PROG && !fsp_protected(lk_addr_q, bp_q)) begin
                        kind_d = FSP_OP_PROG;
                    end
                end
                `FSP_CMD_SECT_A, `FSP_CMD_SECT_B: begin
                    addr_d = {lk_addr_q[23:12], 12'h000};
                    if (wel_q && lk_cnt_q == `FSP_LEN_ADDR && !fsp_protected(lk_addr_q, bp_q)) begin
                        kind_d = FSP_OP_SECTOR;
                    end
                end
                `FSP_CMD_BLOCK: begin
                    addr_d = {lk_addr_q[23:16], 16'h0000};
                    if (wel_q && lk_cnt_q == `FSP_LEN_ADDR && !fsp_protected(lk_addr_q, bp_q)) begin
                        kind_d = FSP_OP_BLOCK;
                    end
                end
                `FSP_CMD_CHIP_A, `FSP_CMD_CHIP_B: begin
                    addr_d = 24'h00_0000;
                    if (wel_q && lk_cnt_q == `FSP_LEN_CMD && bp_q == 3'h0) begin
                        kind_d = FSP_OP_CHIP;
                    end
                end
                default: ;
            endcase
        end
    end

    // ==========================================
    // operation timer and status bits
    logic [31:0] timer_q;
    logic [7:0] pend_q;
    logic done;

    assign done = busy_q && timer_q == 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            timer_q <= 32'h0000_0000;
        end else if (kind_d != FSP_OP_NONE) begin
            busy_q <= 1'b1;
            timer_q <= 32'(OP_CYCLES - 1);
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            timer_q <= timer_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wel_q <= 1'b0;
        end else if (done || wen_clr) begin
            wel_q <= 1'b0;
        end else if (wen_set) begin
            wel_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q <= `FSP_STATUS_RESET;
        end else if (kind_d == FSP_OP_STATUS) begin
            pend_q <= lk_wdat_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lock_q <= 1'b0;
            bp_q <= 3'h0;
        end else if (done && o_op_kind == FSP_OP_STATUS) begin
            lock_q <= pend_q[`FSP_BIT_LOCK];
            bp_q <= pend_q[`FSP_BIT_BP_HI:`FSP_BIT_BP_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_op_start <= 1'b0;
            o_op_kind <= FSP_OP_NONE;
            o_op_addr <= 24'h00_0000;
        end else begin
            o_op_start <= kind_d != FSP_OP_NONE;
            if (kind_d != FSP_OP_NONE) begin
                o_op_kind <= kind_d;
                o_op_addr <= addr_d;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status <= `FSP_STATUS_RESET;
            o_busy <= 1'b0;
            o_wel <= 1'b0;
        end else begin
            o_status <= {lock_q, 2'b00, bp_q, wel_q, busy_q};
            o_busy <= busy_q;
            o_wel <= wel_q;
        end
    end

    // ==========================================
    // checks
    logic [31:0] chk_len_q;

    always_ff @(posedge i_clk) begin
        if (i_rst || !busy_q) begin
            chk_len_q <= 32'h0000_0000;
        end else begin
            chk_len_q <= chk_len_q + 32'h0000_0001;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_busy_len: assert property ($fell(busy_q) |-> $past(chk_len_q) == 32'(OP_CYCLES - 1))
        else $error("busy length wrong");
    chk_wel_gate: assert property (o_op_start |-> $past(wel_q, 2))
        else $error("write started without latch");
    chk_wel_done: assert property ($fell(busy_q) |-> !wel_q)
        else $error("latch kept after operation");
    chk_wel_set: assert property (frame_end && !busy_q && whole && lk_op_q == `FSP_CMD_EN_WR
        && lk_cnt_q == `FSP_LEN_CMD |=> wel_q ##1 o_wel)
        else $error("latch not set");
    chk_rsvd_zero: assert property (o_status[6:5] == 2'b00)
        else $error("reserved bits set");
    chk_lock_gate: assert property (o_op_start && o_op_kind == FSP_OP_STATUS |-> $past(!locked, 2))
        else $error("status write while locked");
    chk_chip_bp: assert property (o_op_start && o_op_kind == FSP_OP_CHIP |-> bp_q == 3'h0)
        else $error("chip erase with protection");
    chk_prot_area: assert property (o_op_start && o_op_kind inside {FSP_OP_PROG, FSP_OP_SECTOR, FSP_OP_BLOCK}
        |-> !fsp_protected(o_op_addr, bp_q))
        else $error("write into protected area");
    chk_busy_ignore: assert property (busy_q && $past(busy_q) |-> kind_d == FSP_OP_NONE && !wen_set)
        else $error("command accepted while busy");
    chk_start_busy: assert property (o_op_start |-> busy_q ##1 o_busy)
        else $error("start without busy");

    cov_status_wr: cover property (o_op_start && o_op_kind == FSP_OP_STATUS);
    cov_chip: cover property (o_op_start && o_op_kind == FSP_OP_CHIP);
    cov_prog_done: cover property (o_op_kind == FSP_OP_PROG && $fell(busy_q));
    cov_locked: cover property (frame_end && lk_op_q == `FSP_CMD_ST_WR && wel_q && locked);

endmodule : fsp_status_protect

`default_nettype wire

// ==== fsp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module fsp_host_model (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    logic [7:0] rx;

    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        rx = 8'h00;
    end

    // ====================
    // one frame, msb first, sck idles low between frames
    task automatic frame(input int nbits, input logic [47:0] data);
        @(negedge i_clk);
        o_cs_n = 1'b0;
        #37;
        for (int i = 0; i < nbits; i++) begin
            o_si = data[47 - i];
            #80 o_sck = 1'b1;
            if (i_so_oe === 1'b1) begin
                rx = {rx[6:0], i_so};
            end
            #80 o_sck = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        // released line shows the inverse of the last bit
        o_si = ~o_si;
        // gap lets the clock side see the rise before the next frame
        repeat (5) @(posedge i_clk);
        #1;
    endtask : frame
endmodule : fsp_host_model

`default_nettype wire

// ==== test_flash_status_write_protect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end

module test_flash_status_write_protect import fsp_pkg::*;;
    logic clk, rst, sck, cs_n, si, wp_n, so, so_oe, busy, write_enable_latch, op_start;
    logic [7:0] status;
    logic [23:0] op_addr;
    fsp_op_type op_kind;
    int n_fail = 0;
    int total_checks = 0;
    int n_starts = 0;
    localparam logic [39:0] Z40 = 40'h00_0000_0000;

    fsp_status_protect #(.IS_4MBIT(1'b1), .OP_CYCLES(600)) uut (.i_clk(clk), .i_rst(rst), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_wel(write_enable_latch),
        .o_status(status), .o_op_start(op_start), .o_op_kind(op_kind), .o_op_addr(op_addr));
    fsp_host_model host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (op_start === 1'b1) n_starts++;
    end

    // ====================
    // helpers
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k == 2000) begin
            n_fail++;
            give_verdict;
        end
        repeat (2) @(negedge clk);
    endtask : wait_idle

    task automatic en;
        host.frame(8, {`FSP_CMD_EN_WR, Z40});
    endtask : en

    task automatic wr_st(input logic [7:0] v);
        en();
        host.frame(16, {`FSP_CMD_ST_WR, v, 32'h0000_0000});
        wait_idle();
    endtask : wr_st

    task automatic try_op(input int nb, input logic [47:0] d, input bit ok, input fsp_op_type kd,
        input logic [23:0] ad);
        int s;
        s = n_starts;
        en();
        host.frame(nb, d);
        `CHK("op start", s + int'(ok), n_starts)
        if (ok) begin
            `CHK("op kind", kd, op_kind)
            `CHK("op addr", ad, op_addr)
            wait_idle();
            `CHK("wel done", 1'b0, write_enable_latch)
        end else begin
            `CHK("wel kept", 1'b1, write_enable_latch)
        end
    endtask : try_op

    // ====================
    // scenarios
    task automatic t_reset;
        `CHK("status", 8'h00, status)
        `CHK("wel", 1'b0, write_enable_latch)
        host.frame(16, {`FSP_CMD_ST_RD, Z40});
        `CHK("read", 8'h00, host.rx)
        $display("test reset done");
    endtask : t_reset

    task automatic t_wel;
        int s;
        s = n_starts;
        host.frame(16, {`FSP_CMD_ST_WR, 8'h9C, 32'h0000_0000});
        `CHK("start", s, n_starts)
        `CHK("status", 8'h00, status)
        host.frame(9, {`FSP_CMD_EN_WR, Z40});
        `CHK("wel", 1'b0, write_enable_latch)
        en();
        `CHK("status", 8'h02, status)
        host.frame(8, {`FSP_CMD_DIS_WR, Z40});
        `CHK("wel", 1'b0, write_enable_latch)
        $display("test latch done");
    endtask : t_wel

    task automatic t_stwr;
        int s;
        en();
        s = n_starts;
        host.frame(16, {`FSP_CMD_ST_WR, 8'hFC, 32'h0000_0000});
        `CHK("start", s + 1, n_starts)
        `CHK("busy", 1'b1, busy)
        `CHK("kind", FSP_OP_STATUS, op_kind)
        host.frame(8, {`FSP_CMD_DIS_WR, Z40});
        `CHK("wel", 1'b1, write_enable_latch)
        host.frame(16, {`FSP_CMD_ST_RD, Z40});
        `CHK("read", 8'h03, host.rx)
        wait_idle();
        `CHK("status", 8'h9C, status)
        $display("test status write done");
    endtask : t_stwr

    task automatic t_lock;
        @(negedge clk) wp_n = 1'b0;
        en();
        host.frame(16, {`FSP_CMD_ST_WR, 8'h00, 32'h0000_0000});
        `CHK("status", 8'h9E, status)
        @(negedge clk) wp_n = 1'b1;
        repeat (4) @(negedge clk);
        host.frame(16, {`FSP_CMD_ST_WR, 8'h00, 32'h0000_0000});
        wait_idle();
        `CHK("status", 8'h00, status)
        $display("test lock done");
    endtask : t_lock

    task automatic t_protect;
        logic [23:0] lo [4];
        logic [2:0] bp [4];
        lo = '{24'h07_0000, 24'h06_0000, 24'h04_0000, 24'h00_0000};
        bp = '{3'b001, 3'b010, 3'b011, 3'b100};
        for (int i = 0; i < 4; i++) begin
            wr_st({3'b000, bp[i], 2'b00});
            try_op(32, {`FSP_CMD_BLOCK, lo[i], 16'h0000}, 1'b0, FSP_OP_NONE, 24'h00_0000);
            if (lo[i] != 24'h00_0000) begin
                try_op(32, {`FSP_CMD_SECT_A, lo[i] - 24'h00_0001, 16'h0000}, 1'b1, FSP_OP_SECTOR,
                    lo[i] - 24'h00_1000);
            end
        end
        try_op(8, {`FSP_CMD_CHIP_A, Z40}, 1'b0, FSP_OP_NONE, 24'h00_0000);
        wr_st(8'h00);
        try_op(8, {`FSP_CMD_CHIP_B, Z40}, 1'b1, FSP_OP_CHIP, 24'h00_0000);
        try_op(41, {`FSP_CMD_PROG, 24'h01_2345, 16'hA500}, 1'b0, FSP_OP_NONE, 24'h00_0000);
        try_op(40, {`FSP_CMD_PROG, 24'h01_2345, 16'hA500}, 1'b1, FSP_OP_PROG, 24'h01_2345);
        try_op(32, {`FSP_CMD_BLOCK, 24'h05_1234, 16'h0000}, 1'b1, FSP_OP_BLOCK, 24'h05_0000);
        try_op(32, {`FSP_CMD_SECT_B, 24'h00_3FFF, 16'h0000}, 1'b1, FSP_OP_SECTOR, 24'h00_3000);
        $display("test protect done");
    endtask : t_protect

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_reset();
        t_wel();
        t_stwr();
        t_lock();
        t_protect();
        give_verdict();
    end
endmodule : test_flash_status_write_protect

`default_nettype wire
